/* include/clkgen_regs.vh */
// register map, field positions, reset values and timing for clock generation
`ifndef CLKGEN_REGS_VH
`define CLKGEN_REGS_VH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define OFS_CLOCK_CONTROL  8'h00
`define OFS_RC_TRIM        8'h04
`define OFS_CPU_DIVISOR    8'h08
`define OFS_AUX_FUNCTION   8'h0C
`define OFS_CLOCK_STATUS   8'h10

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CC_SWITCH_DONE     7
`define CC_XTAL_WDT        4
`define CC_DOUBLER         3
`define TR_RC_CLK_SEL      7
`define TR_CLKOUT_EN       6
`define AUX_LOW_POWER      7
`define USER_CONFIG_BYTE_ONE_SRC_MSB      2
`define USER_CONFIG_BYTE_TWO_DOUBLER      7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_CLOCK_CONTROL  8'h80
`define RST_CPU_DIVISOR    8'h00
`define RST_SOURCE         3'h0

// ----------------------------------------------------------------------
// oscillator source codes
// ----------------------------------------------------------------------
`define SRC_XTAL_HIGH      3'h0
`define SRC_XTAL_MED       3'h1
`define SRC_XTAL_LOW       3'h2
`define SRC_RC             3'h3
`define SRC_WDT            3'h4
`define SRC_EXT            3'h7

// ----------------------------------------------------------------------
// wake-up timing
// ----------------------------------------------------------------------
`define HCLK_MHZ           50
`define XTAL_WAKE_OSC      11'h400
`define SHORT_WAKE_OSC     11'h020
`define XTAL_WAKE_US       60
`define XTAL_WAKE_CYC      14'd3000
`define RC_WAKE_US         200
`define RC_WAKE_CYC        14'd10000

`endif

/* src/cpu_clock_divider.v */
// oscillator clock divider producing the cpu clock enable
`timescale 1ns/1ps
`default_nettype none

module cpu_clock_divider
(
    input  wire       clk,
    input  wire       rst_n,
    input  wire       osc_tick,
    input  wire       run,
    input  wire [7:0] divisor,
    output reg        tick_ff
);

    reg  [8:0] count_ff;

    // factor is 2*m, or 1 for m = 0; so 255 gives the largest factor, 510
    function [8:0] last_count;
        input [7:0] m;
        begin
            if (m == 8'h00)
                last_count = 9'h000;
            else
                last_count = {m, 1'b0} - 9'h001;
        end
    endfunction

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    // compare with >= so a smaller divisor written mid-count takes effect
    // at once without wrapping; the period only ever ends at a whole tick
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_ff <= 9'h000;
            tick_ff  <= 1'b0;
        end
        else if (!run)
        begin
            count_ff <= 9'h000; // [R23]
            tick_ff  <= 1'b0;
        end
        else if (osc_tick)
        begin
            if (count_ff >= last_count(divisor)) // [R18] [R19]
            begin
                count_ff <= 9'h000;
                tick_ff  <= 1'b1;
            end
            else
            begin
                count_ff <= count_ff + 9'h001;
                tick_ff  <= 1'b0;
            end
        end
        else
        begin
            tick_ff <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* src/clk_wakeup_timer.v */
// wake-up delay timer: oscillator ticks then a fixed stretch of time
`timescale 1ns/1ps
`default_nettype none

`include "clkgen_regs.vh"

module clk_wakeup_timer
#(
    parameter [13:0] RC_WAKE_CYC = 14'd10000
)
(
    input  wire       clk,
    input  wire       rst_n,
    input  wire       start,
    input  wire       osc_tick,
    input  wire [2:0] src,
    output reg        busy_ff,
    output reg        done_ff
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_OSC  = 3'b010;
    localparam [2:0] ST_TIME = 3'b100;
    localparam [13:0] XTAL_CYC = `XTAL_WAKE_CYC;

    reg  [2:0]  state_ff;
    reg  [10:0] osc_cnt_ff;
    reg  [13:0] time_cnt_ff;

    function is_xtal;
        input [2:0] s;
        begin
            is_xtal = (s == `SRC_XTAL_HIGH) || (s == `SRC_XTAL_MED) ||
                      (s == `SRC_XTAL_LOW);
        end
    endfunction

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff    <= ST_IDLE;
            osc_cnt_ff  <= 11'h000;
            time_cnt_ff <= 14'h0000;
            busy_ff     <= 1'b0;
            done_ff     <= 1'b0;
        end
        else if (start)
        begin
            state_ff <= ST_OSC;
            busy_ff  <= 1'b1;
            done_ff  <= 1'b0;
            if (is_xtal(src))
            begin
                osc_cnt_ff  <= `XTAL_WAKE_OSC;  // [R15]
                time_cnt_ff <= XTAL_CYC;        // [R15]
            end
            else if (src == `SRC_RC)
            begin
                osc_cnt_ff  <= 11'h000;
                time_cnt_ff <= RC_WAKE_CYC;     // [R16]
            end
            else
            begin
                osc_cnt_ff  <= `SHORT_WAKE_OSC; // [R17]
                time_cnt_ff <= 14'h0000;
            end
        end
        else
        begin
            done_ff <= 1'b0;
            case (state_ff)
                ST_OSC:
                begin
                    if (osc_cnt_ff == 11'h000)
                        state_ff <= ST_TIME;
                    else if (osc_tick)
                        osc_cnt_ff <= osc_cnt_ff - 11'h001;
                end
                ST_TIME:
                begin
                    if (time_cnt_ff == 14'h0000)
                    begin
                        state_ff <= ST_IDLE;
                        busy_ff  <= 1'b0;
                        done_ff  <= 1'b1;
                    end
                    else
                        time_cnt_ff <= time_cnt_ff - 14'h0001;
                end
                ST_IDLE:
                    state_ff <= ST_IDLE;
                default:
                begin
                    state_ff <= ST_IDLE;
                    busy_ff  <= 1'b0;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

/* src/system_clock_generation.v */
// clock source selection, wake-up gating, cpu divider and clock output
//
// Operation
// [R1] machine cycle spans exactly two cpu clocks
// [R2] peripheral clock runs at half cpu clock
// [R3] oscillator clock picked from four sources
// [R4] rc clock nominal, doubled when doubler set
// [R5] crystal clocks watchdog only in low-speed option
// [R6] clock out only when enabled, crystal unused
// [R7] clock out toggles at half cpu clock
// [R8] six-bit rc trim loaded at reset, writable
// [R9] low-power bit clear on reset, software sets
// [R10] doubler use needs both brownout enables set; the doubler bit is taken here without any brownout check
// [R11] external clock above 12 MHz needs brownout; the external source is accepted here without any brownout check
// [R12] external clock accepted from 0 Hz upward
// [R13] switch-complete flag clears, then sets when done
// [R14] clock control writes refused while switching
// [R15] crystal wake-up: 1024 ticks plus time
// [R16] rc wake-up: fixed 200 to 300 us
// [R17] watchdog or external wake-up: 32 ticks
// [R18] cpu clock divided, factor up to 510
// [R19] divisor change applies anytime without stalling
// [R20] source choice comes from nonvolatile configuration
// [R21] source and doubler bits loaded from configuration
// [R22] trim register: select, clock out, tuning
// [R23] switching gates cpu clock until source ready
`timescale 1ns/1ps
`default_nettype none

`include "clkgen_regs.vh"

module system_clock_generation
#(
    parameter [13:0] RC_WAKE_CYC = `RC_WAKE_CYC
)
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire        hwrite,
    input  wire [1:0]  htrans,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        wdt_osc_tick,
    input  wire        rc_osc_tick,
    input  wire        rc_osc_dbl_tick,
    input  wire        xtal_osc_tick,
    input  wire        ext_clk_tick,
    input  wire [7:0]  user_config_byte_one,
    input  wire [7:0]  user_config_byte_two,
    input  wire [5:0]  factory_trim,
    input  wire        rtc_uses_crystal,
    input  wire        wake_request,
    output reg         oscillator_clock,
    output wire        cpu_clock,
    output reg         peripheral_clock,
    output reg         machine_cycle,
    output reg         crystal_output_pin_out,
    output reg         crystal_output_pin_oe_n,
    output reg  [5:0]  rc_trim,
    output reg         rc_clock_select,
    output reg         low_power_clock_mode,
    output reg         watchdog_uses_crystal,
    output reg         switch_complete_flag,
    output reg  [2:0]  active_source
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg         load_cfg_ff;
    reg         wr_pend_ff;
    reg  [7:0]  wr_addr_ff;
    reg  [2:0]  cfg_src_ff;
    reg         cfg_dbl_ff;
    reg         xtal_wdt_ff;
    reg         active_dbl_ff;
    reg         clkout_en_ff;
    reg  [7:0]  divisor_ff;
    reg         cpu_phase_ff;
    reg         wake_start_ff;
    reg  [2:0]  wake_src_ff;
    wire        wake_busy;
    wire        wake_done;
    wire        wake_tick;
    wire        addr_phase;
    wire        src_changes;
    wire [7:0]  wr_byte;
    wire        clkout_allowed;

    function is_xtal;
        input [2:0] s;
        begin
            is_xtal = (s == `SRC_XTAL_HIGH) || (s == `SRC_XTAL_MED) ||
                      (s == `SRC_XTAL_LOW);
        end
    endfunction

    // one oscillator tick stream per source code; unused codes fall to rc
    function pick_tick;
        input [2:0] s;
        input       dbl;
        input       t_wdt;
        input       t_rc;
        input       t_rc2;
        input       t_xtal;
        input       t_ext;
        begin
            if (is_xtal(s))
                pick_tick = t_xtal;
            else if (s == `SRC_WDT)
                pick_tick = t_wdt;
            else if (s == `SRC_EXT)
                pick_tick = t_ext;
            else
                pick_tick = dbl ? t_rc2 : t_rc;
        end
    endfunction

    assign addr_phase  = hsel && hready && htrans[1];
    assign wr_byte     = hwdata[7:0];
    assign src_changes = (wr_byte[2:0] != active_source) ||
                         (wr_byte[`CC_DOUBLER] != active_dbl_ff);
    assign clkout_allowed = clkout_en_ff && !is_xtal(active_source) &&
                            !rtc_uses_crystal && !xtal_wdt_ff;
    assign wake_tick = pick_tick(wake_src_ff, cfg_dbl_ff, wdt_osc_tick,
                                 rc_osc_tick, rc_osc_dbl_tick,
                                 xtal_osc_tick, ext_clk_tick);

    // ------------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata     <= 32'h0000_0000;
            hreadyout  <= 1'b0;
            hresp      <= 1'b0;
        end
        else
        begin
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            wr_pend_ff <= addr_phase && hwrite;
            if (addr_phase)
                wr_addr_ff <= haddr[7:0];
            if (addr_phase && !hwrite)
            begin
                case (haddr[7:0])
                    `OFS_CLOCK_CONTROL:
                        hrdata <= {24'h000000, switch_complete_flag, 2'b00,
                                   xtal_wdt_ff, cfg_dbl_ff, cfg_src_ff};
                    `OFS_RC_TRIM:
                        hrdata <= {24'h000000, rc_clock_select,
                                   clkout_en_ff, rc_trim}; // [R22]
                    `OFS_CPU_DIVISOR:
                        hrdata <= {24'h000000, divisor_ff};
                    `OFS_AUX_FUNCTION:
                        hrdata <= {24'h000000, low_power_clock_mode,
                                   7'h00};
                    `OFS_CLOCK_STATUS:
                        hrdata <= {28'h0000000, active_dbl_ff,
                                   active_source == `SRC_EXT,
                                   wake_busy, !wake_busy};
                    default:
                        hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration and software registers
    // ------------------------------------------------------------------
    // configuration pins are captured on the first edge after reset
    // release, since an asynchronous reset may only load constants
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            load_cfg_ff          <= 1'b1;
            cfg_src_ff           <= `RST_SOURCE;
            cfg_dbl_ff           <= 1'b0;
            xtal_wdt_ff          <= 1'b0;
            active_source        <= `RST_SOURCE;
            active_dbl_ff        <= 1'b0;
            switch_complete_flag <= 1'b1;
            rc_trim              <= 6'h00;
            rc_clock_select      <= 1'b0;
            clkout_en_ff         <= 1'b0;
            divisor_ff           <= `RST_CPU_DIVISOR;
            low_power_clock_mode <= 1'b0; // [R9]
            wake_start_ff        <= 1'b0;
            wake_src_ff          <= 3'h0;
        end
        else
        begin
            load_cfg_ff   <= 1'b0;
            wake_start_ff <= 1'b0;
            if (load_cfg_ff)
            begin
                // [R20] [R21]
                cfg_src_ff    <= user_config_byte_one[`USER_CONFIG_BYTE_ONE_SRC_MSB:0];
                active_source <= user_config_byte_one[`USER_CONFIG_BYTE_ONE_SRC_MSB:0];
                wake_src_ff   <= user_config_byte_one[`USER_CONFIG_BYTE_ONE_SRC_MSB:0];
                cfg_dbl_ff    <= user_config_byte_two[`USER_CONFIG_BYTE_TWO_DOUBLER];
                active_dbl_ff <= user_config_byte_two[`USER_CONFIG_BYTE_TWO_DOUBLER];
                rc_trim       <= factory_trim; // [R8]
                wake_start_ff <= 1'b1;
            end
            else if (wake_done && !switch_complete_flag)
            begin
                active_source        <= wake_src_ff; // [R23]
                active_dbl_ff        <= cfg_dbl_ff;
                switch_complete_flag <= 1'b1;        // [R13]
            end
            else if (wake_request && !wake_busy)
            begin
                wake_src_ff   <= active_source;
                wake_start_ff <= 1'b1;
            end

            if (wr_pend_ff && !load_cfg_ff)
            begin
                case (wr_addr_ff)
                    `OFS_CLOCK_CONTROL:
                    begin
                        // refused while a switch is in flight
                        if (switch_complete_flag && !wake_busy) // [R14]
                        begin
                            cfg_src_ff  <= wr_byte[2:0];           // [R3]
                            cfg_dbl_ff  <= wr_byte[`CC_DOUBLER];   // [R4]
                            xtal_wdt_ff <= wr_byte[`CC_XTAL_WDT];
                            if (src_changes)
                            begin
                                switch_complete_flag <= 1'b0;      // [R13]
                                wake_src_ff   <= wr_byte[2:0];
                                wake_start_ff <= 1'b1;
                            end
                        end
                    end
                    `OFS_RC_TRIM:
                    begin
                        rc_trim         <= wr_byte[5:0];            // [R8]
                        clkout_en_ff    <= wr_byte[`TR_CLKOUT_EN];  // [R22]
                        rc_clock_select <= wr_byte[`TR_RC_CLK_SEL];
                    end
                    `OFS_CPU_DIVISOR:
                        divisor_ff <= wr_byte;                      // [R19]
                    `OFS_AUX_FUNCTION:
                        low_power_clock_mode <= wr_byte[`AUX_LOW_POWER];
                    default:
                        divisor_ff <= divisor_ff;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // oscillator clock and derived enables
    // ------------------------------------------------------------------
    // every source is an enable stream in the hclk domain, so an external
    // clock may stop entirely without upsetting any logic here
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            oscillator_clock      <= 1'b0;
            peripheral_clock      <= 1'b0;
            machine_cycle         <= 1'b0;
            cpu_phase_ff          <= 1'b0;
            watchdog_uses_crystal <= 1'b0;
        end
        else
        begin
            // [R3] [R4] [R12]
            oscillator_clock <= pick_tick(active_source, active_dbl_ff,
                                          wdt_osc_tick, rc_osc_tick,
                                          rc_osc_dbl_tick, xtal_osc_tick,
                                          ext_clk_tick);
            // [R5]
            watchdog_uses_crystal <= xtal_wdt_ff &&
                                     (active_source == `SRC_XTAL_LOW);
            if (cpu_clock)
                cpu_phase_ff <= !cpu_phase_ff;
            peripheral_clock <= cpu_clock && cpu_phase_ff; // [R2]
            machine_cycle    <= cpu_clock && cpu_phase_ff; // [R1]
        end
    end

    // ------------------------------------------------------------------
    // clock output pin
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            crystal_output_pin_out  <= 1'b0;
            crystal_output_pin_oe_n <= 1'b1;
        end
        else if (clkout_allowed) // [R6]
        begin
            crystal_output_pin_oe_n <= 1'b0;
            if (cpu_clock)
                crystal_output_pin_out <= !crystal_output_pin_out; // [R7]
        end
        else
        begin
            crystal_output_pin_out  <= 1'b0;
            crystal_output_pin_oe_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------
    clk_wakeup_timer
    #(
        .RC_WAKE_CYC (RC_WAKE_CYC)
    )
    u_wakeup
    (
        .clk      (hclk),
        .rst_n    (hresetn),
        .start    (wake_start_ff),
        .osc_tick (wake_tick),
        .src      (wake_src_ff),
        .busy_ff  (wake_busy),
        .done_ff  (wake_done)
    );

    // cpu clock is held low for the whole wake-up of the new source
    cpu_clock_divider u_divider
    (
        .clk      (hclk),
        .rst_n    (hresetn),
        .osc_tick (oscillator_clock),
        .run      (!wake_busy && !wake_start_ff && !load_cfg_ff), // [R23]
        .divisor  (divisor_ff),
        .tick_ff  (cpu_clock)
    );

endmodule

`default_nettype wire

/* bench/osc_sources.sv */
// oscillator source models: free-running one-cycle tick streams
`timescale 1ns/1ps
`default_nettype none

module osc_sources
(
    input  wire logic clk,
    output logic      wdt_osc_tick,
    output logic      rc_osc_tick,
    output logic      rc_osc_dbl_tick,
    output logic      xtal_osc_tick,
    output logic      ext_clk_tick
);
    // one period of 60 holds every rate below a whole number of times
    int n = 0;
    always @(posedge clk)
        n <= (n + 1) % 60;
    assign wdt_osc_tick    = (n % 5) == 0;
    assign rc_osc_tick     = (n % 4) == 0;
    assign rc_osc_dbl_tick = (n % 2) == 0;
    assign xtal_osc_tick   = (n % 3) == 0;
    assign ext_clk_tick    = (n % 2) == 1;
endmodule

`default_nettype wire

/* bench/system_clock_generation_checker.sv */
// port-level assertions for the clock generation block
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_regs.vh"

module system_clock_generation_checker
(
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       wdt_osc_tick,
    input wire logic       oscillator_clock,
    input wire logic       cpu_clock,
    input wire logic       peripheral_clock,
    input wire logic       machine_cycle,
    input wire logic       crystal_output_pin_out,
    input wire logic       crystal_output_pin_oe_n,
    input wire logic       low_power_clock_mode,
    input wire logic       watchdog_uses_crystal,
    input wire logic       switch_complete_flag,
    input wire logic [2:0] active_source
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic [1:0] n_cc_ff = 2'h0;
    always @(posedge hclk)
        n_cc_ff <= (machine_cycle ? 2'h0 : n_cc_ff) + {1'b0, cpu_clock};

    a_machine_cycle: assert property (
        machine_cycle |-> n_cc_ff == 2'h2) else $error("machine cycle");
    a_periph_half: assert property (
        peripheral_clock |-> $past(cpu_clock)) else $error("pclk rate");
    a_osc_follow: assert property (
        switch_complete_flag && $past(switch_complete_flag) &&
        active_source == `SRC_WDT && $past(active_source) == `SRC_WDT
        |-> oscillator_clock == $past(wdt_osc_tick)) else $error("osc sel");
    a_clkout_gate: assert property (
        !crystal_output_pin_oe_n |-> $past(active_source) >= `SRC_RC &&
        !$past(watchdog_uses_crystal)) else $error("clock out gate");
    a_clkout_half: assert property (
        !crystal_output_pin_oe_n && $past(!crystal_output_pin_oe_n) &&
        $changed(crystal_output_pin_out) |-> $past(cpu_clock))
        else $error("clock out rate");
    a_cpu_gated: assert property (
        !switch_complete_flag && !$past(switch_complete_flag)
        |-> !cpu_clock) else $error("cpu clock not gated");
    a_switch_flag: assert property (
        $past(hresetn, 2) && $changed(active_source)
        |-> $rose(switch_complete_flag)) else $error("switch flag");
    a_lp_reset: assert property (
        $rose(hresetn) |-> !low_power_clock_mode) else $error("low power");
endmodule

bind system_clock_generation system_clock_generation_checker chk_inst (
    .hclk, .hresetn, .wdt_osc_tick, .oscillator_clock, .cpu_clock,
    .peripheral_clock, .machine_cycle, .crystal_output_pin_out,
    .crystal_output_pin_oe_n, .low_power_clock_mode,
    .watchdog_uses_crystal, .switch_complete_flag, .active_source);

`default_nettype wire

/* bench/system_clock_generation_test.sv */
// self-checking bench for the clock generation block
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_regs.vh"

module system_clock_generation_test;
    logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2, active_source;
    logic        hready, hreadyout, hresp, wake_request = 1'h0;
    logic        wdt_osc_tick, rc_osc_tick, rc_osc_dbl_tick, xtal_osc_tick;
    logic        ext_clk_tick, rtc_uses_crystal = 1'h0;
    // rc source, both brownout enables set
    logic [7:0]  user_config_byte_one = 8'h2B;
    logic [7:0]  user_config_byte_two = 8'h00;
    logic [5:0]  factory_trim = 6'h2A, rc_trim;
    logic        oscillator_clock, cpu_clock, peripheral_clock, machine_cycle;
    logic        crystal_output_pin_out, crystal_output_pin_oe_n;
    logic        rc_clock_select, low_power_clock_mode, watchdog_uses_crystal;
    logic        switch_complete_flag;
    int          miscompares = 0, n_tests = 0;

    assign hready = hreadyout;
    always #10 hclk = ~hclk;

    system_clock_generation #(.RC_WAKE_CYC(14'd20))
        system_clock_generation_inst (
        .hclk, .hresetn, .hsel, .haddr, .hwrite, .htrans, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .wdt_osc_tick, .rc_osc_tick,
        .rc_osc_dbl_tick, .xtal_osc_tick, .ext_clk_tick, .factory_trim,
        .user_config_byte_one, .user_config_byte_two, .rtc_uses_crystal,
        .wake_request, .oscillator_clock, .cpu_clock, .peripheral_clock,
        .machine_cycle, .crystal_output_pin_out, .crystal_output_pin_oe_n,
        .rc_trim, .rc_clock_select, .low_power_clock_mode,
        .watchdog_uses_crystal, .switch_complete_flag, .active_source);

    osc_sources osc_sources_inst (.clk(hclk), .wdt_osc_tick, .rc_osc_tick,
        .rc_osc_dbl_tick, .xtal_osc_tick, .ext_clk_tick);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one single transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'h1);
        rd = hrdata;
    endtask

    // edges until the next cpu clock pulse
    task automatic gap(output int k);
        k = 0;
        do
        begin
            @(posedge hclk);
            k++;
        end
        while (cpu_clock !== 1'h1 && k < 3000);
    endtask

    task automatic t_regs;
        bus(1'h0, `OFS_CLOCK_CONTROL, 32'h0);
        chk(rd, 32'h83);
        bus(1'h0, `OFS_RC_TRIM, 32'h0);
        chk(rd, 32'h2A);
        bus(1'h0, `OFS_AUX_FUNCTION, 32'h0);
        chk(rd, 32'h0);
        bus(1'h0, 8'h20, 32'h0);
        chk(rd, 32'h0);
    endtask

    task automatic t_clkout;
        int k;
        bus(1'h1, `OFS_RC_TRIM, 32'hD5);
        bus(1'h0, `OFS_RC_TRIM, 32'h0);
        chk(rd, 32'hD5);
        chk({rc_clock_select, rc_trim}, 7'h55);
        gap(k);
        gap(k);
        chk(crystal_output_pin_oe_n, 1'h0);
        rtc_uses_crystal <= 1'h1;
        repeat (3) @(posedge hclk);
        chk(crystal_output_pin_oe_n, 1'h1);
        rtc_uses_crystal <= 1'h0;
        bus(1'h1, `OFS_AUX_FUNCTION, 32'h80);
        bus(1'h0, `OFS_AUX_FUNCTION, 32'h0);
        chk(rd, 32'h80);
        chk(low_power_clock_mode, 1'h1);
    endtask

    task automatic t_switch;
        int k;
        bus(1'h1, `OFS_CLOCK_CONTROL, 32'h04);
        bus(1'h0, `OFS_CLOCK_CONTROL, 32'h0);
        chk(rd[7], 1'h0);
        // refused while the switch is under way
        bus(1'h1, `OFS_CLOCK_CONTROL, 32'h07);
        k = 0;
        while (switch_complete_flag !== 1'h1 && k < 2000)
        begin
            @(posedge hclk);
            k++;
        end
        chk(active_source, `SRC_WDT);
        chk(k > 140 && k < 170, 1'h1);
        bus(1'h0, `OFS_CLOCK_CONTROL, 32'h0);
        chk(rd, 32'h84);
        wake_request <= 1'h1;
        @(posedge hclk);
        wake_request <= 1'h0;
        @(posedge hclk);
        gap(k);
        chk(k > 150, 1'h1);
    endtask

    // watchdog ticks come every 5 clocks
    task automatic t_div(input logic [7:0] m, input int f);
        int k;
        bus(1'h1, `OFS_CPU_DIVISOR, {24'h0, m});
        gap(k);
        gap(k);
        chk(k, f * 5);
    endtask

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        t_regs;
        t_clkout;
        t_switch;
        t_div(8'h00, 1);
        t_div(8'h02, 4);
        t_div(8'hFF, 510);
        tally_and_finish;
    end

    initial
    begin
        #400000;
        miscompares++;
        tally_and_finish;
    end
endmodule

`default_nettype wire
